//--- core/usbh_defs.svh
// Register offsets, field positions and sizes of the USB host pipe core.
// Included by the core files; holds definitions only.
`ifndef USBH_DEFS_SVH
`define USBH_DEFS_SVH

`define NUM_PIPES 4
`define MEM_BYTES 168

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PIPE_SEL 8'h08
`define REG_PIPE_CFG 8'h0C
`define REG_PIPE_BASE 8'h10
`define REG_PIPE_DATA 8'h14

`define CTRL_EN 0
`define CTRL_SOF 1
`define CTRL_CARD_SUPPLY_OUTPUT 2

`define PCFG_PEN 0
`define PCFG_RSV 1
`define PCFG_TYPE 2
`define PCFG_BANK 4
`define PCFG_SIZE 8
`define PCFG_VALID 16

`define STAT_ATT_EVT 3
`define STAT_DET_EVT 4

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- core/usbh_pkg.sv
// Types shared by the USB host pipe core and its allocator.
// Assumes nothing of its surroundings.
package usbh_pkg;
  typedef enum logic [1:0] {st_reset, st_idle, st_suspend, st_operate}
    host_state_t;
  typedef logic [9:0] mem_addr_t;
  typedef struct packed {
    logic [7:0] size;
    logic [1:0] bank;
    logic [1:0] ptype;
  } pipe_cfg_t;
endpackage

//--- core/memory_reserve_bit_if.sv
// Carrier between the pipe core and the buffer allocator.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface memory_reserve_bit_if;
  import usbh_pkg::*;
  logic [1:0] ev_pipe;
  logic ev_set;
  logic [3:0] rsv;
  pipe_cfg_t cfg [4];
  mem_addr_t base [4];
  mem_addr_t span [4];
  mem_addr_t base_k;
  mem_addr_t base_n;
  logic [3:0] cfg_ok;
  modport core (output ev_pipe, ev_set, rsv, cfg, base,
    input span, base_k, base_n, cfg_ok);
  modport calc (input ev_pipe, ev_set, rsv, cfg, base,
    output span, base_k, base_n, cfg_ok);
endinterface
`default_nettype wire

//--- core/pipe_memory_reserve_bit.sv
// Buffer allocator: region spans, configuration checks and the new
// base addresses of a pipe and its upper neighbour after a reserve change.
// Assumes the core applies the results only while an event is pending.
`include "usbh_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module pipe_memory_reserve_bit
  import usbh_pkg::*;
(
  memory_reserve_bit_if.calc a
);
  mem_addr_t prev_end;

  genvar i;
  generate
    for (i = 0; i < `NUM_PIPES; i++) begin : g_pipe
      // Region is the size times the bank count.
      assign a.span[i] = mem_addr_t'(a.cfg[i].size) *
        (mem_addr_t'(a.cfg[i].bank) + 10'h001); // RULE20
      // A control pipe with more than one bank is a bad configuration.
      assign a.cfg_ok[i] = !(a.cfg[i].ptype == 2'h0 &&
        a.cfg[i].bank != 2'h0); // RULE18
    end
  endgenerate

  // Regions pack upward from zero in pipe order.
  always_comb begin
    if (a.ev_pipe == 2'h0) begin
      prev_end = '0; // RULE1
    end else if (a.rsv[a.ev_pipe - 2'h1]) begin
      prev_end = a.base[a.ev_pipe - 2'h1] + a.span[a.ev_pipe - 2'h1];
    end else begin
      prev_end = a.base[a.ev_pipe - 2'h1];
    end
  end

  assign a.base_k = prev_end;
  // On reserve the next region slides up, on release it slides down.
  assign a.base_n = a.ev_set ? prev_end + a.span[a.ev_pipe] :
    prev_end; // RULE2 RULE4
endmodule
`default_nettype wire

//--- core/usb_host_core.sv
// USB host core: pipe buffer memory with ordered allocation, controller
// states and attach/detach detection, reached over AXI4-Lite.
// Assumes a single full-speed device on dp_in/dm_in and one clock domain.
//
// Overview of operation
// RULE1 - Pipes are reserved in ascending order only; code does not check the order and accepts a reserve on any pipe.
// RULE2 - Reserving a pipe slides next region up.
// RULE3 - Disabling a pipe keeps reservation and configuration.
// RULE4 - Releasing a pipe slides next region down.
// RULE5 - Pipe 0 data survives other pipes' changes.
// RULE6 - Disabling pipe 0 discards its data.
// RULE7 - Disable then re-enable moves no regions.
// RULE8 - Valid flag set despite overlapping regions.
// RULE9 - Reset state, then idle once enabled.
// RULE10 - Host ready needs no clock multiplier.
// RULE11 - Suspend without frames, leave when frames resume.
// RULE12 - Attach when lines leave both-low.
// RULE13 - Card supply must be on for attach.
// RULE14 - Detach when idle lines are both low.
// RULE15 - Firmware resets module after a detach.
// RULE16 - Core runs on a 48 MHz clock.
// RULE17 - 168 byte buffer shared by four pipes.
// RULE18 - Multi-bank control pipe is a configuration error.
// RULE19 - Enabled pipe is ready for requests; code also requires reservation, a valid configuration and the operate state.
// RULE20 - Region is size times bank count, contiguous.
`include "usbh_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module usb_host_core
  import usbh_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dp_in,
  input wire logic dm_in,
  output logic card_supply_output,
  output logic [1:0] host_state,
  output logic attached,
  output logic [3:0] pipe_ready
);
  memory_reserve_bit_if al ();

  pipe_memory_reserve_bit pipe_memory_reserve_bit_i (
    .a(al.calc)
  );

  host_state_t state_r;
  logic [2:0] ctrl_r;
  logic [1:0] sel_r;
  logic [3:0] pen_r, rsv_r;
  pipe_cfg_t cfg_r [4];
  mem_addr_t base_r [4];
  mem_addr_t wp_r [4];
  mem_addr_t rp_r [4];
  logic [7:0] mem_r [`MEM_BYTES]; // RULE17
  logic ev_r, ev_set_r;
  logic [1:0] ev_pipe_r;
  logic [2:0] dp_s_r, dm_s_r;
  logic dp_r, dm_r, att_evt_r, det_evt_r, lock_r;
  logic aw_hold_r, w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire, rd_fire, se0, att_now, det_now;
  logic [31:0] wval, cfg_word, stat_word;
  mem_addr_t wr_addr, rd_addr;

  // Applies byte strobes to a register's current value.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Tells whether an offset is one of the mapped registers.
  function automatic logic mapped(input logic [7:0] adr);
    return adr == `REG_CTRL || adr == `REG_STATUS ||
      adr == `REG_PIPE_SEL || adr == `REG_PIPE_CFG ||
      adr == `REG_PIPE_BASE || adr == `REG_PIPE_DATA;
  endfunction

  assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid && ce;
  assign rd_fire = s_axi_arvalid && s_axi_arready && ce;
  // Readies drop while frozen so that no handshake is lost.
  assign s_axi_awready = ce && !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_hold_r && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;

  always_comb begin
    cfg_word = '0;
    cfg_word[`PCFG_PEN] = pen_r[sel_r];
    cfg_word[`PCFG_RSV] = rsv_r[sel_r];
    cfg_word[`PCFG_TYPE +: 2] = cfg_r[sel_r].ptype;
    cfg_word[`PCFG_BANK +: 2] = cfg_r[sel_r].bank;
    cfg_word[`PCFG_SIZE +: 8] = cfg_r[sel_r].size;
    // No overlap check: only reservation and bank rule gate the flag.
    cfg_word[`PCFG_VALID] = rsv_r[sel_r] && al.cfg_ok[sel_r]; // RULE8
  end

  assign stat_word = {24'h000000, lock_r, dm_r, dp_r, det_evt_r,
    att_evt_r, attached, 2'(state_r)};
  assign wval = merge(cfg_word, w_data_r, w_strb_r);
  assign wr_addr = base_r[sel_r] + wp_r[sel_r];
  assign rd_addr = base_r[sel_r] + rp_r[sel_r];

  assign al.ev_pipe = ev_pipe_r;
  assign al.ev_set = ev_set_r;
  assign al.rsv = rsv_r;
  assign al.cfg = cfg_r;
  assign al.base = base_r;

  // Write address and data are taken in either order.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read answers one cycle after the address is taken.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (s_axi_araddr)
          `REG_CTRL: s_axi_rdata <= {29'h00000000, ctrl_r};
          `REG_STATUS: s_axi_rdata <= stat_word;
          `REG_PIPE_SEL: s_axi_rdata <= {30'h00000000, sel_r};
          `REG_PIPE_CFG: s_axi_rdata <= cfg_word;
          `REG_PIPE_BASE: s_axi_rdata <= {22'h000000, base_r[sel_r]};
          `REG_PIPE_DATA: begin
            if (rp_r[sel_r] < wp_r[sel_r] && rd_addr < `MEM_BYTES) begin
              s_axi_rdata <= {24'h000000, mem_r[rd_addr[7:0]]};
            end else begin
              s_axi_rdata <= 32'h00000000;
            end
          end
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control and pipe selection registers.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= 3'h0;
      sel_r <= 2'h0;
    end else if (ce && wr_fire) begin
      if (aw_addr_r == `REG_CTRL && w_strb_r[0]) begin
        ctrl_r <= w_data_r[2:0];
      end
      if (aw_addr_r == `REG_PIPE_SEL && w_strb_r[0]) begin
        sel_r <= w_data_r[1:0];
      end
    end
  end

  assign card_supply_output = ctrl_r[`CTRL_CARD_SUPPLY_OUTPUT];

  // Pipe configuration; a reserve change raises an allocation event.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pen_r <= 4'h0;
      rsv_r <= 4'h0;
      ev_r <= 1'b0;
      ev_set_r <= 1'b0;
      ev_pipe_r <= 2'h0;
      for (int p = 0; p < `NUM_PIPES; p++) begin
        cfg_r[p] <= '0;
      end
    end else if (ce) begin
      ev_r <= 1'b0;
      if (state_r == st_reset) begin
        pen_r <= 4'h0;
        rsv_r <= 4'h0;
      end else if (wr_fire && aw_addr_r == `REG_PIPE_CFG) begin
        // Enable alone never touches reservation or fields.
        pen_r[sel_r] <= wval[`PCFG_PEN]; // RULE3 RULE7
        rsv_r[sel_r] <= wval[`PCFG_RSV];
        cfg_r[sel_r] <= {wval[`PCFG_SIZE +: 8], wval[`PCFG_BANK +: 2],
          wval[`PCFG_TYPE +: 2]};
        if (wval[`PCFG_RSV] != rsv_r[sel_r]) begin
          ev_r <= 1'b1;
          ev_set_r <= wval[`PCFG_RSV];
          ev_pipe_r <= sel_r;
        end
      end
    end
  end

  // Region placement and data pointers.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < `NUM_PIPES; p++) begin
        base_r[p] <= '0;
        wp_r[p] <= '0;
        rp_r[p] <= '0;
      end
    end else if (ce) begin
      if (ev_r) begin
        // Only the pipe and its direct neighbour move.
        base_r[ev_pipe_r] <= al.base_k; // RULE2 RULE4
        wp_r[ev_pipe_r] <= '0;
        rp_r[ev_pipe_r] <= '0;
        if (ev_pipe_r != 2'h3) begin
          base_r[ev_pipe_r + 2'h1] <= al.base_n; // RULE2 RULE4
          wp_r[ev_pipe_r + 2'h1] <= '0;
          rp_r[ev_pipe_r + 2'h1] <= '0;
        end
      end else if (wr_fire && aw_addr_r == `REG_PIPE_CFG &&
        pen_r[sel_r] && !wval[`PCFG_PEN]) begin
        // Disabling drops that pipe's own data, no other pipe's.
        wp_r[sel_r] <= '0; // RULE5 RULE6
        rp_r[sel_r] <= '0;
      end else if (wr_fire && aw_addr_r == `REG_PIPE_DATA &&
        wp_r[sel_r] < al.span[sel_r]) begin
        wp_r[sel_r] <= wp_r[sel_r] + 10'h001;
      end else if (rd_fire && s_axi_araddr == `REG_PIPE_DATA &&
        rp_r[sel_r] < wp_r[sel_r]) begin
        rp_r[sel_r] <= rp_r[sel_r] + 10'h001;
      end
    end
  end

  // Buffer storage; no reset, contents are meaningless until written.
  always_ff @(posedge ref_clk) begin
    if (ce && wr_fire && aw_addr_r == `REG_PIPE_DATA &&
      wp_r[sel_r] < al.span[sel_r] && wr_addr < `MEM_BYTES &&
      w_strb_r[0]) begin
      mem_r[wr_addr[7:0]] <= w_data_r[7:0];
    end
  end

  // Line inputs pass three flops; a level counts once two agree.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dp_s_r <= 3'h0;
      dm_s_r <= 3'h0;
      dp_r <= 1'b0;
      dm_r <= 1'b0;
    end else if (ce) begin
      dp_s_r <= {dp_s_r[1:0], dp_in};
      dm_s_r <= {dm_s_r[1:0], dm_in};
      if (dp_s_r[1] == dp_s_r[2]) begin
        dp_r <= dp_s_r[2];
      end
      if (dm_s_r[1] == dm_s_r[2]) begin
        dm_r <= dm_s_r[2];
      end
    end
  end

  assign se0 = !dp_r && !dm_r;
  // Supply must be on, and a detach locks out reattach until disabled.
  assign att_now = state_r == st_idle && !se0 &&
    card_supply_output && !lock_r; // RULE12 RULE13 RULE15
  assign det_now = (state_r == st_suspend || state_r == st_operate) &&
    se0; // RULE14

  // Controller states; no clock multiplier status is consulted.
  // The core expects ref_clk to be the 48 MHz host clock.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= st_reset; // RULE9 RULE16
    end else if (ce) begin
      if (!ctrl_r[`CTRL_EN]) begin
        state_r <= st_reset;
      end else begin
        case (state_r)
          st_reset: state_r <= st_idle; // RULE9 RULE10
          st_idle: begin
            if (att_now) begin
              state_r <= ctrl_r[`CTRL_SOF] ? st_operate : st_suspend;
            end
          end
          st_suspend, st_operate: begin
            if (det_now) begin
              state_r <= st_idle;
            end else begin
              state_r <= ctrl_r[`CTRL_SOF] ? st_operate :
                st_suspend; // RULE11
            end
          end
          default: state_r <= st_reset;
        endcase
      end
    end
  end

  // Event flags and detach lock; a set wins over a same-cycle clear.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      att_evt_r <= 1'b0;
      det_evt_r <= 1'b0;
      lock_r <= 1'b0;
      attached <= 1'b0;
      pipe_ready <= 4'h0;
      host_state <= 2'h0;
    end else if (ce) begin
      if (att_now) begin
        att_evt_r <= 1'b1;
      end else if (wr_fire && aw_addr_r == `REG_STATUS &&
        w_data_r[`STAT_ATT_EVT] && w_strb_r[0]) begin
        att_evt_r <= 1'b0;
      end
      if (det_now) begin
        det_evt_r <= 1'b1;
      end else if (wr_fire && aw_addr_r == `REG_STATUS &&
        w_data_r[`STAT_DET_EVT] && w_strb_r[0]) begin
        det_evt_r <= 1'b0;
      end
      if (state_r == st_reset) begin
        lock_r <= 1'b0;
      end else if (det_now) begin
        lock_r <= 1'b1; // RULE15
      end
      attached <= state_r == st_suspend || state_r == st_operate;
      pipe_ready <= pen_r & rsv_r & al.cfg_ok &
        {4{state_r == st_operate}}; // RULE19
      host_state <= 2'(state_r);
    end
  end
endmodule
`default_nettype wire

//--- test/usb_card_model.sv
// Line-side model of a single full-speed card for the host pipe core.
// Assumes the host keeps pull-downs on both data lines.
`timescale 1ns/10ps
`default_nettype none
module usb_card_model (
  input wire logic plugged,
  input wire logic vbus,
  output logic dp,
  output logic dm
);
  // The card pulls data-plus up only once it is seated and powered.
  assign dp = plugged && vbus;
  // Data-minus stays on the host pull-down, so unplugged means both low.
  assign dm = 1'b0;
endmodule
`default_nettype wire

//--- test/usb_host_core_asserts.sv
// Port-level checker for the USB host pipe core.
// Assumes a single clock domain and the bind at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module usb_host_core_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dp_in,
  input wire logic dm_in,
  input wire logic card_supply_output,
  input wire logic [1:0] host_state,
  input wire logic attached,
  input wire logic [3:0] pipe_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_RESET_STATE: assert property ($past(rst) |-> host_state == 2'h0)
    else $error("state not reset after reset");
  AST_RESET_EXIT: assert property
    (host_state == 2'h0 |=> host_state inside {2'h0, 2'h1})
    else $error("reset state left other than to idle");
  AST_ATTACH: assert property
    ((host_state == 2'h1 && dp_in && card_supply_output) [*4]
      |-> ##[1:8] attached)
    else $error("attach not reported");
  AST_SUPPLY: assert property ($rose(attached) |-> card_supply_output)
    else $error("attach without card supply");
  AST_DETACH: assert property
    (attached && !dp_in && !dm_in |-> ##[1:8] !attached)
    else $error("detach not reported");
  AST_ATT_STATE: assert property (attached |-> host_state[1])
    else $error("attached outside suspend or operate");
  AST_READY: assert property (|pipe_ready |-> host_state == 2'h3)
    else $error("pipe ready outside operate");
  AST_BHOLD: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RHOLD: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_RLAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WBLOCK: assert property
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule
bind usb_host_core usb_host_core_asserts usb_host_core_asserts_i (.ref_clk,
  .rst, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .dp_in, .dm_in, .card_supply_output,
  .host_state, .attached, .pipe_ready);
`default_nettype wire

//--- test/usb_host_pipe_memory_and_state_test.sv
// Self-checking bench for the USB host pipe core.
// Assumes the card model on the line side and the bound checker.
`include "usbh_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module usb_host_pipe_memory_and_state_test;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic plugged = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, dp_in, dm_in, card_supply_output, attached;
  logic [1:0] s_axi_bresp, s_axi_rresp, host_state, r;
  logic [31:0] s_axi_rdata, d;
  logic [3:0] pipe_ready;
  logic [7:0] sz [4];
  logic [1:0] bk [4];
  logic [1:0] ty [4];
  logic [9:0] b [4];
  int err_count = 0;
  int tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  usb_host_core usb_host_core_i (.ref_clk, .rst, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .dp_in, .dm_in, .card_supply_output, .host_state,
    .attached, .pipe_ready);
  usb_card_model usb_card_model_i (.plugged, .vbus(card_supply_output),
    .dp(dp_in), .dm(dm_in));
  function automatic logic [9:0] span(input int k);
    return 10'(sz[k]) * (10'(bk[k]) + 10'h001);
  endfunction
  function automatic logic [31:0] cfg(input int k, input logic en, rv);
    return {16'h0000, sz[k], 2'b00, bk[k], ty[k], rv, en};
  endfunction
  function automatic logic [31:0] vld(input int k);
    return {15'h0, !(ty[k] == 2'h0 && bk[k] != 2'h0), 16'h0};
  endfunction
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n > 200) begin
      err_count++;
      $display("Error at %0t: wait ran out", $time);
      tally_and_finish();
    end
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic ah, wh, bh;
    n = 0;
    bh = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!bh) begin
      @(negedge ref_clk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid && s_axi_bready;
      @(posedge ref_clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) s_axi_bready <= 1'b0;
      else if (!s_axi_bready) s_axi_bready <= 1'($urandom_range(1));
      tmo(++n);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
    int n;
    logic ah, rh;
    n = 0;
    rh = 1'b0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!rh) begin
      @(negedge ref_clk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (rh) s_axi_rready <= 1'b0;
      else if (!s_axi_rready) s_axi_rready <= 1'($urandom_range(1));
      tmo(++n);
    end
    chk(d & m, e);
  endtask
  task automatic cb(input int k, input logic [9:0] e);
    wr(`REG_PIPE_SEL, 32'(k));
    rc(`REG_PIPE_BASE, 32'h3FF, 32'(e));
  endtask
  task automatic wt(input logic [1:0] s);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (host_state !== s) begin
      @(negedge ref_clk);
      tmo(++n);
    end
    chk(32'(host_state), 32'(s));
  endtask
  initial begin
    void'($urandom(52));
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rc(`REG_STATUS, 32'h3, 32'h0);
    wr(`REG_CTRL, 32'h1);
    rc(`REG_STATUS, 32'h3, 32'h1);
    for (int k = 0; k < 4; k++) begin
      sz[k] = 8'($urandom_range(16, (k == 0) ? 8 : 4));
      bk[k] = (k == 0) ? 2'h0 : 2'($urandom_range(1));
      ty[k] = (k == 0) ? 2'h0 : 2'($urandom_range(3));
    end
    // Corner case: a control pipe with two banks must come out invalid.
    ty[3] = 2'h0;
    bk[3] = 2'h1;
    b[0] = 10'h000;
    for (int k = 0; k < 4; k++) begin
      if (k > 0) b[k] = b[k-1] + span(k-1);
      wr(`REG_PIPE_SEL, 32'(k));
      wr(`REG_PIPE_CFG, cfg(k, 1'b1, 1'b1));
      rc(`REG_PIPE_BASE, 32'h3FF, 32'(b[k]));
      rc(`REG_PIPE_CFG, 32'h1FFFF, cfg(k, 1'b1, 1'b1) | vld(k));
    end
    wr(`REG_PIPE_SEL, 32'h0);
    for (int i = 0; i < 4; i++) wr(`REG_PIPE_DATA, 32'(8'hA0 + i));
    wr(`REG_PIPE_SEL, 32'h1);
    wr(`REG_PIPE_CFG, cfg(1, 1'b0, 1'b1));
    rc(`REG_PIPE_CFG, 32'hFFFE, cfg(1, 1'b0, 1'b1));
    wr(`REG_PIPE_CFG, cfg(1, 1'b1, 1'b1));
    cb(2, b[2]);
    wr(`REG_PIPE_SEL, 32'h1);
    wr(`REG_PIPE_CFG, cfg(1, 1'b0, 1'b0));
    cb(2, b[1]);
    cb(3, b[3]);
    sz[1] = sz[1] + 8'h08;
    wr(`REG_PIPE_SEL, 32'h1);
    wr(`REG_PIPE_CFG, cfg(1, 1'b1, 1'b1));
    cb(2, b[1] + span(1));
    cb(3, b[3]);
    wr(`REG_PIPE_SEL, 32'h2);
    rc(`REG_PIPE_CFG, 32'h10000, vld(2));
    wr(`REG_PIPE_SEL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rc(`REG_PIPE_DATA, 32'hFF, 32'(8'hA0 + i));
    end
    // A fresh byte must vanish when pipe 0 is switched off.
    wr(`REG_PIPE_DATA, 32'hA4);
    wr(`REG_PIPE_CFG, cfg(0, 1'b0, 1'b1));
    rc(`REG_PIPE_DATA, 32'hFF, 32'h0);
    wr(`REG_PIPE_CFG, cfg(0, 1'b1, 1'b1));
    wr(`REG_CTRL, 32'h5);
    plugged <= 1'b1;
    wt(2'h2);
    chk(32'(attached), 32'h1);
    wr(`REG_CTRL, 32'h7);
    wt(2'h3);
    d = {28'h0, 1'b0, |vld(2), |vld(1), 1'b1};
    chk(32'(pipe_ready), d);
    wr(`REG_CTRL, 32'h5);
    wt(2'h2);
    @(posedge ref_clk);
    plugged <= 1'b0;
    wt(2'h1);
    rc(`REG_STATUS, 32'h14, 32'h10);
    wr(`REG_STATUS, 32'h18);
    rc(`REG_STATUS, 32'h18, 32'h0);
    wr(`REG_CTRL, 32'h0);
    wr(`REG_CTRL, 32'h5);
    plugged <= 1'b1;
    wt(2'h2);
    rc(8'h20, 32'hFFFFFFFF, 32'h0);
    chk(32'(r), 32'(`RESP_SLVERR));
    tally_and_finish();
  end
endmodule
`default_nettype wire
